// ---- rtl/conn_status_b.v ----
// connection status word b: capture, packing and register port
`timescale 1ns/100ps
`include "conn_status_b_defines.vh"

// Notes on behaviour
// (RQ1) status word at 0x11, writes ignored
// (RQ2) bits 15:14 show repeat filter state
// (RQ3) bits 13:12 show insertion machine state
// (RQ4) bit 11 set while scrub runs
// (RQ5) bits 10:7 show cm state, reserved never
// (RQ6) line state seen cleared on cm change
// (RQ7) code started flags set at code start
// (RQ8) bits 2:0 hold last break cause
module conn_status_b #(
    parameter ADDR_W = 6,
    parameter DATA_W = 16
) (
    // clock and reset
    input  wire              clk_sys_i,
    input  wire              sys_rst_i,
    // register port
    input  wire [ADDR_W-1:0] reg_addr_i,
    input  wire [DATA_W-1:0] reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [DATA_W-1:0] reg_rdata_o,
    // repeat filter and insertion machine
    input  wire [1:0]        repeat_filter_state_field_i,
    input  wire [1:0]        pci_state_i,
    input  wire              scrub_active_i,
    // connection management machine
    input  wire [3:0]        cm_state_i,
    input  wire              vector_transmit_i,
    input  wire              lss_set_i,
    input  wire              tcs_set_i,
    input  wire              rcs_set_i,
    input  wire              break_i,
    input  wire [2:0]        break_cause_i,
    // live view of the word
    output reg  [DATA_W-1:0] status_word_o,
    output reg               cm_change_o
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [1:0]        repeat_filter_state_field_q;
    reg  [1:0]        pci_state_q;
    reg               scrub_q;
    reg               vector_q;
    reg               hold_q;
    reg               brk_clr_q;
    reg  [DATA_W-1:0] word_d;
    reg  [DATA_W-1:0] rdata_d;
    wire [3:0]        cm_state;
    wire              cm_change;
    wire              line_state_seen_flag;
    wire              transmit_code_started_flag;
    wire              receive_code_started_flag;
    wire [2:0]        break_cause;
    wire              sel_status;
    wire              sel_control;
    wire              ctl_wr;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // only the control register takes writes; the status word has no
    // write path at all, so a stray write cannot disturb it
    assign sel_status  = (reg_addr_i == `CSB_ADDR_STATUS);     // [RQ1]
    assign sel_control = (reg_addr_i == `CSB_ADDR_CONTROL);
    assign ctl_wr      = reg_wr_i && sel_control;

    // ****************************************************************
    // control register
    // ****************************************************************
    // break clear is a one-cycle pulse; hold freezes the live view
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_q    <= 1'b0;
            brk_clr_q <= 1'b0;
        end else begin
            brk_clr_q <= ctl_wr && reg_wdata_i[`CSB_CTL_BRK_CLR_BIT];
            if (ctl_wr) begin
                hold_q <= reg_wdata_i[`CSB_CTL_HOLD_BIT];
            end
        end
    end

    // ****************************************************************
    // capture of machine states
    // ****************************************************************
    // inputs come from logic on this clock, so one stage suffices;
    // the stage keeps all fields of the word aligned in time
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            repeat_filter_state_field_q  <= `CSB_RF_RESET;
            pci_state_q <= `CSB_PCI_RESET;
            scrub_q     <= 1'b0;
            vector_q    <= 1'b0;
        end else begin
            repeat_filter_state_field_q  <= repeat_filter_state_field_i;                         // [RQ2]
            pci_state_q <= pci_state_i;                        // [RQ3]
            scrub_q     <= scrub_active_i;                     // [RQ4]
            vector_q    <= vector_transmit_i;
        end
    end

    // ****************************************************************
    // connection management state and flags
    // ****************************************************************
    cm_state_tracker u_tracker (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .cm_state_i  (cm_state_i),
        .cm_state_o  (cm_state),
        .cm_change_o (cm_change)
    );

    // flags clear on the same edge that the state register moves
    cm_flag_keeper u_flags (
        .clk_sys_i     (clk_sys_i),
        .sys_rst_i     (sys_rst_i),
        .cm_change_i   (cm_change),
        .lss_set_i     (lss_set_i),
        .tcs_set_i     (tcs_set_i),
        .rcs_set_i     (rcs_set_i),
        .break_i       (break_i),
        .break_cause_i (break_cause_i),
        .break_clr_i   (brk_clr_q),
        .lsf_o         (line_state_seen_flag),
        .tcf_o         (transmit_code_started_flag),
        .rcf_o         (receive_code_started_flag),
        .break_cause_o (break_cause)
    );

    // ****************************************************************
    // word packing
    // ****************************************************************
    // break cause takes bits 2:0, so every bit of the word is a field
    always @* begin
        word_d                          = `CSB_WORD_RESET;
        word_d[`CSB_RF_LSB +: 2]        = repeat_filter_state_field_q;          // [RQ2]
        word_d[`CSB_PCI_LSB +: 2]       = pci_state_q;         // [RQ3]
        word_d[`CSB_SCRUB_BIT]          = scrub_q;             // [RQ4]
        word_d[`CSB_CM_LSB +: 4]        = cm_state;            // [RQ5]
        word_d[`CSB_VEC_BIT]            = vector_q;
        word_d[`CSB_LSF_BIT]            = line_state_seen_flag;                 // [RQ6]
        word_d[`CSB_RCF_BIT]            = receive_code_started_flag;                 // [RQ7]
        word_d[`CSB_TCF_BIT]            = transmit_code_started_flag;                 // [RQ7]
        word_d[`CSB_BRK_LSB +: 3]       = break_cause;         // [RQ8]
    end

    // ****************************************************************
    // live view
    // ****************************************************************
    // hold lets software take a coherent snapshot across many reads;
    // the trade-off is that status_word_o freezes along with the read; cm_change_o keeps running
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status_word_o <= `CSB_WORD_RESET;
            cm_change_o   <= 1'b0;
        end else begin
            cm_change_o <= cm_change;                          // [RQ6]
            if (!hold_q) begin
                status_word_o <= word_d;
            end
        end
    end

    // ****************************************************************
    // read mux
    // ****************************************************************
    // unmapped addresses read as zero
    always @* begin
        rdata_d = {DATA_W{1'b0}};
        if (sel_status) begin
            rdata_d = hold_q ? status_word_o : word_d;         // [RQ1]
        end else if (sel_control) begin
            rdata_d[`CSB_CTL_HOLD_BIT] = hold_q;
        end
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= {DATA_W{1'b0}};
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_d;
        end else begin
            reg_rdata_o <= {DATA_W{1'b0}};
        end
    end

endmodule // conn_status_b

// ---- common/conn_status_b_defines.vh ----
// constants for the connection status word b register block
`ifndef CONN_STATUS_B_DEFINES_VH
`define CONN_STATUS_B_DEFINES_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define CSB_ADDR_STATUS     6'h11
`define CSB_ADDR_CONTROL    6'h1F

// ****************************************************************
// field positions in the status word
// ****************************************************************
`define CSB_RF_LSB          4'hE
`define CSB_PCI_LSB         4'hC
`define CSB_SCRUB_BIT       4'hB
`define CSB_CM_LSB          4'h7
`define CSB_VEC_BIT         4'h6
`define CSB_LSF_BIT         4'h5
`define CSB_RCF_BIT         4'h4
`define CSB_TCF_BIT         4'h3
`define CSB_BRK_LSB         4'h0

// ****************************************************************
// field positions in the control register
// ****************************************************************
`define CSB_CTL_BRK_CLR_BIT 4'h0
`define CSB_CTL_HOLD_BIT    4'h1

// ****************************************************************
// codes and reset values
// ****************************************************************
`define CSB_CM_OFF          4'h0
`define CSB_CM_LAST         4'h9
`define CSB_BRK_NONE        3'h0
`define CSB_BRK_LAST        3'h6
`define CSB_RF_RESET        2'h0
`define CSB_PCI_RESET       2'h0
`define CSB_WORD_RESET      16'h0000

`endif

// ---- rtl/cm_state_tracker.v ----
// connection management state capture with reserved code rejection
`timescale 1ns/100ps
`include "conn_status_b_defines.vh"

module cm_state_tracker (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       sys_rst_i,
    // live state from the connection management machine
    input  wire [3:0] cm_state_i,
    // captured state and change strobe
    output reg  [3:0] cm_state_o,
    output wire       cm_change_o
);

    // ****************************************************************
    // capture
    // ****************************************************************
    wire code_ok;

    // reserved codes are dropped so the word never shows them
    assign code_ok     = (cm_state_i <= `CSB_CM_LAST);       // [RQ5]
    assign cm_change_o = code_ok && (cm_state_i != cm_state_o);

    // state register follows every legal code
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cm_state_o <= `CSB_CM_OFF;
        end else if (code_ok) begin
            cm_state_o <= cm_state_i;                          // [RQ5]
        end
    end

endmodule // cm_state_tracker

// ---- rtl/cm_flag_keeper.v ----
// connection management flags and break cause keeper
`timescale 1ns/100ps
`include "conn_status_b_defines.vh"

module cm_flag_keeper (
    // clock and reset
    input  wire       clk_sys_i,
    input  wire       sys_rst_i,
    // state change from the tracker
    input  wire       cm_change_i,
    // flag set pulses
    input  wire       lss_set_i,
    input  wire       tcs_set_i,
    input  wire       rcs_set_i,
    // break event and cause
    input  wire       break_i,
    input  wire [2:0] break_cause_i,
    input  wire       break_clr_i,
    // kept flags
    output reg        lsf_o,
    output reg        tcf_o,
    output reg        rcf_o,
    output reg  [2:0] break_cause_o
);

    // ****************************************************************
    // flags
    // ****************************************************************
    wire brk_ok;

    // cause 000 and 111 carry no break meaning
    assign brk_ok = break_i && (break_cause_i != `CSB_BRK_NONE) &&
                    (break_cause_i <= `CSB_BRK_LAST);

    // a set in the same cycle as a clear wins, so no event is lost
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lsf_o         <= 1'b0;
            tcf_o         <= 1'b0;
            rcf_o         <= 1'b0;
            break_cause_o <= `CSB_BRK_NONE;
        end else begin
            if (lss_set_i) begin
                lsf_o <= 1'b1;
            end else if (cm_change_i) begin
                lsf_o <= 1'b0;                                 // [RQ6]
            end
            if (tcs_set_i) begin
                tcf_o <= 1'b1;                                 // [RQ7]
            end else if (cm_change_i) begin
                tcf_o <= 1'b0;
            end
            if (rcs_set_i) begin
                rcf_o <= 1'b1;                                 // [RQ7]
            end else if (cm_change_i) begin
                rcf_o <= 1'b0;
            end
            if (brk_ok) begin
                break_cause_o <= break_cause_i;                // [RQ8]
            end else if (break_clr_i) begin
                break_cause_o <= `CSB_BRK_NONE;                // [RQ8]
            end
        end
    end

endmodule // cm_flag_keeper

// ---- verif/conn_status_b_asserts.sv ----
// checker for the connection status word b block
`timescale 1ns/100ps
module conn_status_b_chk #(
    parameter ADDR_W = 6,
    parameter DATA_W = 16
) (
    // clock, reset and register port
    input wire              clk_sys_i,
    input wire              sys_rst_i,
    input wire [ADDR_W-1:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire              reg_wr_i,
    input wire              reg_rd_i,
    input wire [DATA_W-1:0] reg_rdata_o,
    // machine inputs and word
    input wire [1:0]        repeat_filter_state_field_i,
    input wire [1:0]        pci_state_i,
    input wire              scrub_active_i,
    input wire [3:0]        cm_state_i,
    input wire              lss_set_i,
    input wire [DATA_W-1:0] status_word_o,
    input wire              cm_change_o
);
    reg       hold_q;
    reg [1:0] held_q;
    wire      frozen;
    // freeze tracked here; the word lags the hold bit by two edges,
    // so tracking checks stay off until the word is live again
    always @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hold_q <= 1'b0;
            held_q <= 2'h0;
        end else begin
            held_q <= {held_q[0], hold_q};
            if (reg_wr_i && reg_addr_i == 6'h1F)
                hold_q <= reg_wdata_i[1];
        end
    end
    assign frozen = hold_q || (held_q != 2'h0);
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_rd_word: assert property (
        reg_rd_i && reg_addr_i == 6'h11 |=> reg_rdata_o == status_word_o)
        else $error("status read differs from word");
    a_rd_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");
    a_rf_track: assert property (disable iff (sys_rst_i || frozen)
        status_word_o[15:14] == $past(repeat_filter_state_field_i, 2))
        else $error("repeat filter field wrong");
    a_pci_track: assert property (disable iff (sys_rst_i || frozen)
        status_word_o[13:12] == $past(pci_state_i, 2))
        else $error("insertion field wrong");
    a_scrub_track: assert property (disable iff (sys_rst_i || frozen)
        status_word_o[11] == $past(scrub_active_i, 2))
        else $error("scrub flag wrong");
    a_cm_track: assert property (disable iff (sys_rst_i || frozen)
        $past(cm_state_i, 2) <= 4'h9 |-> status_word_o[10:7] ==
        $past(cm_state_i, 2)) else $error("cm field wrong");
    a_cm_kept: assert property (disable iff (sys_rst_i || frozen)
        $past(cm_state_i, 2) > 4'h9 |-> $stable(status_word_o[10:7]))
        else $error("reserved cm code taken");
    a_cm_legal: assert property (
        status_word_o[10:7] <= 4'h9) else $error("reserved cm code shown");
    a_lsf_clear: assert property (disable iff (sys_rst_i || frozen)
        $rose(cm_change_o) && !$past(lss_set_i) |-> ##[0:2] !status_word_o[5])
        else $error("line state flag not cleared");
    a_cm_change: assert property (disable iff (sys_rst_i || frozen)
        cm_change_o == ($past(cm_state_i) <= 4'h9 &&
        $past(cm_state_i) != status_word_o[10:7]))
        else $error("cm change strobe wrong");
    a_brk_legal: assert property (
        status_word_o[2:0] != 3'h7) else $error("break cause 7 shown");
    c_rd: cover property (reg_rd_i && reg_addr_i == 6'h11);
    c_change: cover property ($rose(cm_change_o));
    c_hold: cover property (hold_q && reg_rd_i);
endmodule // conn_status_b_chk

// ---- verif/tb_top.sv ----
// self-checking bench for the connection status word b block
`timescale 1ns/100ps
module tb_top;
    reg         clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, rd_seen;
    reg  [5:0]  reg_addr_i;
    reg  [15:0] reg_wdata_i, frz;
    reg  [1:0]  repeat_filter_state_field_i, pci_state_i;
    reg         scrub_active_i, vector_transmit_i, lss_set_i, tcs_set_i;
    reg         rcs_set_i, break_i, lsf_m, tcf_m, rcf_m;
    reg  [3:0]  cm_state_i, cm_m;
    reg  [2:0]  break_cause_i, brk_m;
    reg  [31:0] rnd;
    wire [15:0] reg_rdata_o, status_word_o;
    wire        cm_change_o;
    reg  [15:0] exp_q[$];
    integer     failures, n_checks, seed, i;
    // expected word from the bench's own model of the flags
    wire [15:0] exp_w = {repeat_filter_state_field_i, pci_state_i, scrub_active_i, cm_m,
                         vector_transmit_i, lsf_m, rcf_m, tcf_m, brk_m};
    conn_status_b i_conn_status_b (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .repeat_filter_state_field_i(repeat_filter_state_field_i),
        .pci_state_i(pci_state_i), .scrub_active_i(scrub_active_i),
        .cm_state_i(cm_state_i), .vector_transmit_i(vector_transmit_i),
        .lss_set_i(lss_set_i), .tcs_set_i(tcs_set_i), .rcs_set_i(rcs_set_i),
        .break_i(break_i), .break_cause_i(break_cause_i),
        .status_word_o(status_word_o), .cm_change_o(cm_change_o));
    // ****************************************************************
    // clock, tasks and result watcher
    // ****************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task wr(input [5:0] a, input [15:0] d);
        begin
            @(posedge clk_sys_i);
            reg_wr_i    <= 1'b1;
            reg_addr_i  <= a;
            reg_wdata_i <= d;
            @(posedge clk_sys_i);
            reg_wr_i    <= 1'b0;
        end
    endtask
    task rd(input [5:0] a, input [15:0] e);
        begin
            exp_q.push_back(e);
            @(posedge clk_sys_i);
            reg_rd_i   <= 1'b1;
            reg_addr_i <= a;
            @(posedge clk_sys_i);
            reg_rd_i   <= 1'b0;
        end
    endtask
    // one-cycle set pulses; cause 0 and 7 leave the kept cause alone
    task pulse(input f, input b, input [2:0] c);
        begin
            @(posedge clk_sys_i);
            {lss_set_i, tcs_set_i, rcs_set_i} <= {3{f}};
            break_i       <= b;
            break_cause_i <= c;
            @(posedge clk_sys_i);
            {lss_set_i, tcs_set_i, rcs_set_i, break_i} <= 4'h0;
            if (f)
                {lsf_m, tcf_m, rcf_m} = 3'h7;
            if (b && c != 3'h0 && c != 3'h7)
                brk_m = c;
        end
    endtask
    // a legal new code clears the flags, a reserved one is dropped
    task set_cm(input [3:0] c);
        begin
            @(posedge clk_sys_i);
            cm_state_i <= c;
            if (c <= 4'h9 && c != cm_m) begin
                cm_m = c;
                {lsf_m, tcf_m, rcf_m} = 3'h0;
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // read data stand one cycle after the strobe; look mid-cycle
    always @(posedge clk_sys_i) rd_seen <= reg_rd_i;
    always @(negedge clk_sys_i) begin
        if (rd_seen)
            check(reg_rdata_o, exp_q.pop_front());
    end
    initial begin
        #20000;
        failures = failures + 1;
        end_sim;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        seed = 32'h445d7230;
        {failures, n_checks, rd_seen, sys_rst_i} = 0;
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, repeat_filter_state_field_i} = 0;
        {pci_state_i, scrub_active_i, vector_transmit_i, cm_state_i} = 0;
        {lss_set_i, tcs_set_i, rcs_set_i, break_i, break_cause_i} = 0;
        {cm_m, brk_m, lsf_m, tcf_m, rcf_m} = 0;
        sys_rst_i = 1'b1;
        tick(2);
        sys_rst_i <= 1'b0;
        tick(3);
        rd(6'h11, 16'h0000);
        rd(6'h1F, 16'h0000);
        rd(6'h05, 16'h0000);
        // first sixteen passes walk every code, the rest are random
        for (i = 0; i < 40; i = i + 1) begin
            rnd = $random(seed);
            if (i < 16) begin
                rnd[3:0]   = i;
                rnd[9:6]   = i;
                rnd[14:10] = {i[2:0], 2'h3};
            end
            @(posedge clk_sys_i);
            {scrub_active_i, pci_state_i, repeat_filter_state_field_i} <= rnd[4:0];
            vector_transmit_i <= rnd[5];
            pulse(rnd[10], rnd[11], rnd[14:12]);
            set_cm(rnd[9:6]);
            wr(6'h11, rnd[31:16]);
            tick(3);
            rd(6'h11, exp_w);
        end
        // set pulses on the edge of a cm change: the sets must win
        @(posedge clk_sys_i);
        {lss_set_i, tcs_set_i, rcs_set_i} <= 3'h7;
        cm_state_i <= (cm_m == 4'h9) ? 4'h0 : cm_m + 4'h1;
        @(posedge clk_sys_i);
        {lss_set_i, tcs_set_i, rcs_set_i} <= 3'h0;
        cm_m = cm_state_i;
        {lsf_m, tcf_m, rcf_m} = 3'h7;
        tick(2);
        rd(6'h11, exp_w);
        wr(6'h1F, 16'h0001);
        brk_m = 3'h0;
        tick(2);
        rd(6'h11, exp_w);
        wr(6'h1F, 16'h0002);
        tick(3);
        frz = exp_w;
        repeat_filter_state_field_i <= ~repeat_filter_state_field_i;
        tick(3);
        rd(6'h11, frz);
        rd(6'h1F, 16'h0002);
        // releasing hold must bring the live word back
        wr(6'h1F, 16'h0000);
        tick(3);
        rd(6'h11, exp_w);
        tick(4);
        end_sim;
    end
endmodule // tb_top
bind conn_status_b conn_status_b_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    i_conn_status_b_chk (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .repeat_filter_state_field_i(repeat_filter_state_field_i), .pci_state_i(pci_state_i),
    .scrub_active_i(scrub_active_i), .cm_state_i(cm_state_i),
    .lss_set_i(lss_set_i), .status_word_o(status_word_o),
    .cm_change_o(cm_change_o));
